// ==== rtl/atr_pkg.sv ====
// package: register map, field layout and carrier types of the trim bank
package atr_pkg;

    // register offsets
    localparam logic [7:0] ADDR_DATA_STATUS = 8'h00;
    localparam logic [7:0] ADDR_X_SAMPLE_HIGH = 8'h01;
    localparam logic [7:0] ADDR_X_SAMPLE_LOW = 8'h02;
    localparam logic [7:0] ADDR_Y_SAMPLE_HIGH = 8'h03;
    localparam logic [7:0] ADDR_Y_SAMPLE_LOW = 8'h04;
    localparam logic [7:0] ADDR_Z_SAMPLE_HIGH = 8'h05;
    localparam logic [7:0] ADDR_Z_SAMPLE_LOW = 8'h06;
    localparam logic [7:0] ADDR_OPERATING_STATE = 8'h0b;
    localparam logic [7:0] ADDR_EVENT_SOURCE_FLAGS = 8'h0c;
    localparam logic [7:0] ADDR_PART_IDENTITY = 8'h0d;
    localparam logic [7:0] ADDR_FULL_SCALE_CONFIG = 8'h0e;
    localparam logic [7:0] ADDR_HIGHPASS_CUTOFF_CONFIG = 8'h0f;
    localparam logic [7:0] ADDR_ORIENTATION_STATUS = 8'h10;
    localparam logic [7:0] ADDR_ORIENTATION_CONFIG = 8'h11;
    localparam logic [7:0] ADDR_ORIENTATION_DEBOUNCE = 8'h12;
    localparam logic [7:0] ADDR_ORIENTATION_TILT_COMP = 8'h13;
    localparam logic [7:0] ADDR_ORIENTATION_THRESHOLD = 8'h14;
    localparam logic [7:0] ADDR_FALL_MOTION_CONFIG = 8'h15;
    localparam logic [7:0] ADDR_FALL_MOTION_SOURCE = 8'h16;
    localparam logic [7:0] ADDR_FALL_MOTION_THRESHOLD = 8'h17;
    localparam logic [7:0] ADDR_FALL_MOTION_DEBOUNCE = 8'h18;
    localparam logic [7:0] ADDR_JOLT_CONFIG = 8'h1d;
    localparam logic [7:0] ADDR_JOLT_SOURCE = 8'h1e;
    localparam logic [7:0] ADDR_JOLT_THRESHOLD = 8'h1f;
    localparam logic [7:0] ADDR_JOLT_DEBOUNCE = 8'h20;
    localparam logic [7:0] ADDR_TAP_CONFIG = 8'h21;
    localparam logic [7:0] ADDR_TAP_SOURCE = 8'h22;
    localparam logic [7:0] ADDR_TAP_THRESHOLD_X = 8'h23;
    localparam logic [7:0] ADDR_TAP_THRESHOLD_Y = 8'h24;
    localparam logic [7:0] ADDR_TAP_THRESHOLD_Z = 8'h25;
    localparam logic [7:0] ADDR_TAP_FIRST_TIMER = 8'h26;
    localparam logic [7:0] ADDR_TAP_LATENCY = 8'h27;
    localparam logic [7:0] ADDR_TAP_SECOND_WINDOW = 8'h28;
    localparam logic [7:0] ADDR_AUTOSLEEP_COUNT = 8'h29;
    localparam logic [7:0] ADDR_PRIMARY_CONTROL = 8'h2a;
    localparam logic [7:0] ADDR_SECONDARY_CONTROL = 8'h2b;
    localparam logic [7:0] ADDR_WAKE_SOURCE_CONTROL = 8'h2c;
    localparam logic [7:0] ADDR_INTERRUPT_ENABLE_MAP = 8'h2d;
    localparam logic [7:0] ADDR_INTERRUPT_PIN_ROUTING = 8'h2e;
    localparam logic [7:0] ADDR_X_OFFSET_TRIM = 8'h2f;
    localparam logic [7:0] ADDR_Y_OFFSET_TRIM = 8'h30;
    localparam logic [7:0] ADDR_Z_OFFSET_TRIM = 8'h31;
    localparam logic [7:0] ADDR_LAST_RW = 8'h31;

    // writable-bit masks; zero bits are fixed zero
    localparam logic [7:0] MASK_FULL = 8'hff;
    localparam logic [7:0] MASK_FULL_SCALE = 8'h03;
    localparam logic [7:0] MASK_HIGHPASS = 8'h33;
    localparam logic [7:0] MASK_ORIENT_CFG = 8'hc0;
    localparam logic [7:0] MASK_TILT_COMP = 8'hc7;
    localparam logic [7:0] MASK_FALL_CFG = 8'hf8;
    localparam logic [7:0] MASK_JOLT_CFG = 8'h1f;
    localparam logic [7:0] MASK_TAP_THRESHOLD = 8'h7f;
    localparam logic [7:0] MASK_SECONDARY = 8'hdf;
    localparam logic [7:0] MASK_WAKE = 8'h7b;
    localparam logic [7:0] MASK_INT_MAP = 8'hbd;

    // reset values
    localparam logic [7:0] RESET_REG = 8'h00;
    localparam logic [7:0] RESET_TRIM = 8'h00;

    // field positions
    localparam int FS_LO = 0;
    localparam int CUTOFF_SELECT_LO = 0;
    localparam int CUTOFF_SELECT_HI = 1;
    localparam int TAP_LOWPASS_ENABLE = 4;
    localparam int TAP_HIGHPASS_BYPASS = 5;
    localparam int ACTIVE_BIT = 0;
    localparam int SRC_DATA_READY_BIT = 0;

    // sample and trim widths
    localparam int SAMPLE_W = 10;
    localparam int TRIM_W = 8;

    // host register port request
    typedef struct packed {
        logic rd;
        logic wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } atr_host_req_type;

    // state reported by the detection engines
    typedef struct packed {
        logic [1:0] op_state;
        logic [7:0] event_src;
        logic [7:0] orient_status;
        logic [7:0] fall_src;
        logic [7:0] jolt_src;
        logic [7:0] tap_src;
    } atr_engine_status_type;

    // settings handed to the rest of the device
    typedef struct packed {
        logic active;
        logic [1:0] full_scale;
        logic [1:0] cutoff_select;
        logic tap_highpass_bypass;
        logic tap_lowpass_enable;
        logic [7:0] x_trim;
        logic [7:0] y_trim;
        logic [7:0] z_trim;
    } atr_config_type;

endpackage : atr_pkg

// ==== rtl/atr_register_bank.sv ====
// register bank of the accelerometer with per-axis offset trim
`timescale 1ns/1ps
// Notes on behaviour
// - each axis reading gets a signed per-axis trim added to realign 0 g.
// - one trim step is worth 2 mg of shift in the corrected reading.
// - each trim is an 8-bit two's complement value spanning -256 to +254 mg.
// - after reset all three trims are zero so no shift is applied.
// - the x, y and z trims sit at 0x2f..0x31 and read back as written.
// - tap threshold registers keep bits 6..0 and bit 7 reads zero.
// - the highpass register has cutoff in 1..0, bypass 5, lowpass 4.
// - tilt comp has trip bits 7..6, lock angle 2..0, bits 5..3 zero.
// - the tap first timer is a full 8-bit read/write value.
module atr_register_bank
    import atr_pkg::*;
#(
    parameter logic [7:0] PART_ID = 8'h5a // arbitrary identity value
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire atr_host_req_type host_req,
    output logic [7:0] rd_data,
    output logic rd_valid,
    input wire logic sample_valid,
    input wire logic [SAMPLE_W-1:0] raw_x,
    input wire logic [SAMPLE_W-1:0] raw_y,
    input wire logic [SAMPLE_W-1:0] raw_z,
    input wire atr_engine_status_type engine_status,
    output atr_config_type config_out,
    output logic data_ready
);

    // writable mask per address; zero mask means read-only or unmapped
    function automatic logic [7:0] write_mask(input logic [7:0] addr);
        logic [7:0] m;
        m = 8'h00;
        unique case (addr)
            ADDR_FULL_SCALE_CONFIG: m = MASK_FULL_SCALE;
            ADDR_HIGHPASS_CUTOFF_CONFIG: m = MASK_HIGHPASS;
            ADDR_ORIENTATION_CONFIG: m = MASK_ORIENT_CFG;
            ADDR_ORIENTATION_TILT_COMP: m = MASK_TILT_COMP;
            ADDR_FALL_MOTION_CONFIG: m = MASK_FALL_CFG;
            ADDR_JOLT_CONFIG: m = MASK_JOLT_CFG;
            ADDR_TAP_THRESHOLD_X,
            ADDR_TAP_THRESHOLD_Y,
            ADDR_TAP_THRESHOLD_Z: m = MASK_TAP_THRESHOLD;
            ADDR_SECONDARY_CONTROL: m = MASK_SECONDARY;
            ADDR_WAKE_SOURCE_CONTROL: m = MASK_WAKE;
            ADDR_INTERRUPT_ENABLE_MAP,
            ADDR_INTERRUPT_PIN_ROUTING: m = MASK_INT_MAP;
            ADDR_ORIENTATION_DEBOUNCE,
            ADDR_ORIENTATION_THRESHOLD,
            ADDR_FALL_MOTION_THRESHOLD,
            ADDR_FALL_MOTION_DEBOUNCE,
            ADDR_JOLT_THRESHOLD,
            ADDR_JOLT_DEBOUNCE,
            ADDR_TAP_CONFIG,
            ADDR_TAP_FIRST_TIMER,
            ADDR_TAP_LATENCY,
            ADDR_TAP_SECOND_WINDOW,
            ADDR_AUTOSLEEP_COUNT,
            ADDR_PRIMARY_CONTROL,
            ADDR_X_OFFSET_TRIM,
            ADDR_Y_OFFSET_TRIM,
            ADDR_Z_OFFSET_TRIM: m = MASK_FULL;
            default: m = 8'h00;
        endcase
        return m;
    endfunction : write_mask

    // raw plus trim, trim rescaled from 2 mg steps to the output lsb
    function automatic logic [SAMPLE_W-1:0] apply_trim(
        input logic [SAMPLE_W-1:0] raw,
        input logic [TRIM_W-1:0] trim,
        input logic [1:0] fs
    );
        logic signed [SAMPLE_W+1:0] wide_trim;
        logic signed [SAMPLE_W+1:0] sum;
        logic [1:0] shift;
        wide_trim = '0;
        sum = '0;
        shift = (fs == 2'b11) ? 2'd2 : fs;
        // 2 mg trim over 3.9/7.8/15.6 mg lsb: shift right by fs+1, by 3 for fs 3 as for fs 2
        wide_trim = (SAMPLE_W+2)'(signed'(trim));
        wide_trim = wide_trim >>> (shift + 2'd1);
        sum = (SAMPLE_W+2)'(signed'(raw)) + wide_trim;
        // saturate instead of wrapping so a big trim cannot flip the sign
        if (sum > (SAMPLE_W+2)'(signed'({1'b0, {(SAMPLE_W-1){1'b1}}}))) begin
            return {1'b0, {(SAMPLE_W-1){1'b1}}};
        end else if (sum < (SAMPLE_W+2)'(signed'({1'b1, {(SAMPLE_W-1){1'b0}}})))
        begin
            return {1'b1, {(SAMPLE_W-1){1'b0}}};
        end
        return sum[SAMPLE_W-1:0];
    endfunction : apply_trim

    // read/write register storage, indexed by the low address bits
    logic [7:0] rw_mem_reg [0:63];
    logic [SAMPLE_W-1:0] x_out_reg;
    logic [SAMPLE_W-1:0] y_out_reg;
    logic [SAMPLE_W-1:0] z_out_reg;
    logic [2:0] ready_reg;
    logic [2:0] ready_next;
    logic [2:0] overrun_reg;
    logic [2:0] overrun_next;
    logic [7:0] rd_data_reg;
    logic rd_valid_reg;
    logic data_ready_reg;
    atr_config_type config_reg;

    // decode of the host request
    wire logic [7:0] wr_mask = write_mask(host_req.addr);
    wire logic wr_hit = host_req.wr && (wr_mask != 8'h00);
    wire logic addr_in_mem = host_req.addr <= ADDR_LAST_RW;
    wire logic [5:0] mem_idx = host_req.addr[5:0];
    wire logic [7:0] mem_word = addr_in_mem ? rw_mem_reg[mem_idx] : 8'h00;
    wire logic [7:0] x_trim = rw_mem_reg[ADDR_X_OFFSET_TRIM[5:0]];
    wire logic [7:0] y_trim = rw_mem_reg[ADDR_Y_OFFSET_TRIM[5:0]];
    wire logic [7:0] z_trim = rw_mem_reg[ADDR_Z_OFFSET_TRIM[5:0]];
    wire logic [1:0] full_scale =
        rw_mem_reg[ADDR_FULL_SCALE_CONFIG[5:0]][FS_LO +: 2];

    // reading an axis high byte clears that axis' ready and overrun bits
    wire logic [2:0] clr_axis = {
        host_req.rd && host_req.addr == ADDR_Z_SAMPLE_HIGH,
        host_req.rd && host_req.addr == ADDR_Y_SAMPLE_HIGH,
        host_req.rd && host_req.addr == ADDR_X_SAMPLE_HIGH};
    wire logic [2:0] set_axis = {3{sample_valid}};
    // set wins over clear so a sample in the read cycle is not lost
    assign ready_next = set_axis | (ready_reg & ~clr_axis);
    assign overrun_next = (set_axis & ready_reg) | (overrun_reg & ~clr_axis);

    // read-only images
    wire logic [7:0] status_word = {|overrun_reg, overrun_reg[2],
        overrun_reg[1], overrun_reg[0], |ready_reg, ready_reg[2],
        ready_reg[1], ready_reg[0]};
    wire logic [7:0] event_word = {engine_status.event_src[7:1], |ready_reg};

    // read mux; unmapped addresses read zero
    wire logic [7:0] rd_mux =
        (host_req.addr == ADDR_DATA_STATUS) ? status_word :
        (host_req.addr == ADDR_X_SAMPLE_HIGH) ? x_out_reg[9:2] :
        (host_req.addr == ADDR_X_SAMPLE_LOW) ? {x_out_reg[1:0], 6'h00} :
        (host_req.addr == ADDR_Y_SAMPLE_HIGH) ? y_out_reg[9:2] :
        (host_req.addr == ADDR_Y_SAMPLE_LOW) ? {y_out_reg[1:0], 6'h00} :
        (host_req.addr == ADDR_Z_SAMPLE_HIGH) ? z_out_reg[9:2] :
        (host_req.addr == ADDR_Z_SAMPLE_LOW) ? {z_out_reg[1:0], 6'h00} :
        (host_req.addr == ADDR_OPERATING_STATE) ?
            {6'h00, engine_status.op_state} :
        (host_req.addr == ADDR_EVENT_SOURCE_FLAGS) ? event_word :
        (host_req.addr == ADDR_PART_IDENTITY) ? PART_ID :
        (host_req.addr == ADDR_ORIENTATION_STATUS) ?
            engine_status.orient_status :
        (host_req.addr == ADDR_FALL_MOTION_SOURCE) ? engine_status.fall_src :
        (host_req.addr == ADDR_JOLT_SOURCE) ? engine_status.jolt_src :
        (host_req.addr == ADDR_TAP_SOURCE) ? engine_status.tap_src :
        mem_word;

    // storage: masked writes, all zero after reset
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            for (int i = 0; i < 64; i++) begin
                rw_mem_reg[i] <= RESET_REG;
            end
        end else if (wr_hit) begin
            rw_mem_reg[mem_idx] <= host_req.wdata & wr_mask;
        end
    end

    // corrected samples land in the output registers
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            x_out_reg <= '0;
            y_out_reg <= '0;
            z_out_reg <= '0;
        end else if (sample_valid) begin
            x_out_reg <= apply_trim(raw_x, x_trim, full_scale);
            y_out_reg <= apply_trim(raw_y, y_trim, full_scale);
            z_out_reg <= apply_trim(raw_z, z_trim, full_scale);
        end
    end

    // status flags and host read answer
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            ready_reg <= 3'b000;
            overrun_reg <= 3'b000;
            rd_data_reg <= 8'h00;
            rd_valid_reg <= 1'b0;
            data_ready_reg <= 1'b0;
        end else begin
            ready_reg <= ready_next;
            overrun_reg <= overrun_next;
            rd_data_reg <= host_req.rd ? rd_mux : rd_data_reg;
            rd_valid_reg <= host_req.rd;
            // taken from the next flags so the pin is a flop, same timing
            data_ready_reg <= |ready_next;
        end
    end

    // settings copy; one cycle behind the storage, kept registered
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            config_reg <= '0;
        end else begin
            config_reg.active <=
                rw_mem_reg[ADDR_PRIMARY_CONTROL[5:0]][ACTIVE_BIT];
            config_reg.full_scale <= full_scale;
            config_reg.cutoff_select <= rw_mem_reg[
                ADDR_HIGHPASS_CUTOFF_CONFIG[5:0]][CUTOFF_SELECT_HI:
                CUTOFF_SELECT_LO];
            config_reg.tap_highpass_bypass <= rw_mem_reg[
                ADDR_HIGHPASS_CUTOFF_CONFIG[5:0]][TAP_HIGHPASS_BYPASS];
            config_reg.tap_lowpass_enable <= rw_mem_reg[
                ADDR_HIGHPASS_CUTOFF_CONFIG[5:0]][TAP_LOWPASS_ENABLE];
            config_reg.x_trim <= x_trim;
            config_reg.y_trim <= y_trim;
            config_reg.z_trim <= z_trim;
        end
    end

    assign rd_data = rd_data_reg;
    assign rd_valid = rd_valid_reg;
    assign config_out = config_reg;
    assign data_ready = data_ready_reg;

    // ---- assertions ----
    sequence s_trim_write;
        host_req.wr && !host_req.rd && host_req.addr == ADDR_Y_OFFSET_TRIM;
    endsequence

    sequence s_trim_readback;
        host_req.rd && !host_req.wr && host_req.addr == ADDR_Y_OFFSET_TRIM;
    endsequence

    property p_trim_reset;
        @(posedge core_clk) disable iff (!rst_n)
        !$past(rst_n) |-> x_trim == RESET_TRIM && y_trim == RESET_TRIM &&
            z_trim == RESET_TRIM;
    endproperty
    a_trim_reset: assert property (p_trim_reset)
        else $error("trim not zero after reset");

    property p_trim_readback;
        @(posedge core_clk) disable iff (!rst_n)
        s_trim_write ##1 s_trim_readback |=>
            rd_valid && rd_data == $past(host_req.wdata, 2);
    endproperty
    a_trim_readback: assert property (p_trim_readback)
        else $error("trim readback differs from written value");

    property p_trim_applied;
        @(posedge core_clk) disable iff (!rst_n)
        sample_valid && raw_x == 10'h000 && full_scale == 2'b00 &&
            x_trim == 8'h02 |=> x_out_reg == 10'h001;
    endproperty
    a_trim_applied: assert property (p_trim_applied)
        else $error("two trim steps did not give one lsb at 2g");

    property p_trim_negative;
        @(posedge core_clk) disable iff (!rst_n)
        sample_valid && raw_z == 10'h000 && full_scale == 2'b01 &&
            z_trim == 8'h80 |=> z_out_reg == 10'h3e0;
    endproperty
    a_trim_negative: assert property (p_trim_negative)
        else $error("most negative trim gave wrong shift");

    property p_sample_stored;
        @(posedge core_clk) disable iff (!rst_n)
        sample_valid |=> y_out_reg ==
            apply_trim($past(raw_y), $past(y_trim), $past(full_scale));
    endproperty
    a_sample_stored: assert property (p_sample_stored)
        else $error("output register missed the corrected sample");

    property p_tap_thr_bit7;
        @(posedge core_clk) disable iff (!rst_n)
        host_req.rd && (host_req.addr == ADDR_TAP_THRESHOLD_X ||
            host_req.addr == ADDR_TAP_THRESHOLD_Y ||
            host_req.addr == ADDR_TAP_THRESHOLD_Z) |=> !rd_data[7];
    endproperty
    a_tap_thr_bit7: assert property (p_tap_thr_bit7)
        else $error("tap threshold bit 7 reads one");

    property p_highpass_fields;
        @(posedge core_clk) disable iff (!rst_n)
        host_req.rd && host_req.addr == ADDR_HIGHPASS_CUTOFF_CONFIG |=>
            (rd_data & ~MASK_HIGHPASS) == 8'h00;
    endproperty
    a_highpass_fields: assert property (p_highpass_fields)
        else $error("highpass register shows a fixed-zero bit set");

    property p_tilt_gap;
        @(posedge core_clk) disable iff (!rst_n)
        host_req.rd && host_req.addr == ADDR_ORIENTATION_TILT_COMP |=>
            rd_data[5:3] == 3'b000;
    endproperty
    a_tilt_gap: assert property (p_tilt_gap)
        else $error("tilt comp middle bits read nonzero");

    property p_first_timer_full;
        @(posedge core_clk) disable iff (!rst_n)
        host_req.wr && !host_req.rd && host_req.addr == ADDR_TAP_FIRST_TIMER
            ##1 host_req.rd && host_req.addr == ADDR_TAP_FIRST_TIMER
            |=> rd_data == $past(host_req.wdata, 2);
    endproperty
    a_first_timer_full: assert property (p_first_timer_full)
        else $error("tap first timer lost bits");

    property p_readonly_id;
        @(posedge core_clk) disable iff (!rst_n)
        host_req.rd && host_req.addr == ADDR_PART_IDENTITY |=>
            rd_data == PART_ID;
    endproperty
    a_readonly_id: assert property (p_readonly_id)
        else $error("identity register changed");

    property p_ready_set;
        @(posedge core_clk) disable iff (!rst_n)
        sample_valid |=> ready_reg == 3'b111 && data_ready;
    endproperty
    a_ready_set: assert property (p_ready_set)
        else $error("sample left ready flags low");

    property p_ready_clear;
        @(posedge core_clk) disable iff (!rst_n)
        host_req.rd && host_req.addr == ADDR_X_SAMPLE_HIGH && !sample_valid
            |=> !ready_reg[0] && !overrun_reg[0];
    endproperty
    a_ready_clear: assert property (p_ready_clear)
        else $error("x high byte read kept x flags");

    property p_ro_ignored;
        @(posedge core_clk) disable iff (!rst_n)
        host_req.wr && addr_in_mem && wr_mask == 8'h00 |=>
            rw_mem_reg[$past(mem_idx)] == $past(rw_mem_reg[mem_idx]);
    endproperty
    a_ro_ignored: assert property (p_ro_ignored)
        else $error("read-only write changed storage");

    property p_fixed_zero;
        @(posedge core_clk) disable iff (!rst_n)
        wr_hit |=> (rw_mem_reg[$past(mem_idx)] & ~$past(wr_mask)) == 8'h00;
    endproperty
    a_fixed_zero: assert property (p_fixed_zero)
        else $error("fixed-zero bit stored as one");

    property p_unmapped_read;
        @(posedge core_clk) disable iff (!rst_n)
        host_req.rd && host_req.addr > ADDR_LAST_RW |=> rd_data == 8'h00;
    endproperty
    a_unmapped_read: assert property (p_unmapped_read)
        else $error("unmapped address read nonzero");

    property p_rd_valid_pulse;
        @(posedge core_clk) disable iff (!rst_n)
        1'b1 |=> rd_valid == $past(host_req.rd);
    endproperty
    a_rd_valid_pulse: assert property (p_rd_valid_pulse)
        else $error("read answer flag out of step");

    property p_config_trim;
        @(posedge core_clk) disable iff (!rst_n)
        1'b1 |=> config_out.y_trim == $past(y_trim);
    endproperty
    a_config_trim: assert property (p_config_trim)
        else $error("settings copy lost the y trim");

endmodule : atr_register_bank

// ==== testbench/accel_register_map_offset_trim_bench.sv ====
// self-checking bench of the offset trim register bank
`timescale 1ns/1ps
module accel_register_map_offset_trim_bench
    import atr_pkg::*;
;
    localparam logic [7:0] ID_VAL = 8'h5a; // arbitrary identity value
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic sample_valid = 1'b0;
    logic [SAMPLE_W-1:0] raw_x = '0;
    logic [SAMPLE_W-1:0] raw_y = '0;
    logic [SAMPLE_W-1:0] raw_z = '0;
    atr_engine_status_type engine_status = '0;
    atr_host_req_type host_req;
    logic [7:0] rd_data;
    logic rd_valid;
    atr_config_type config_out;
    logic data_ready;
    int n_errors = 0;
    int num_checks = 0;
    logic [8:0] r;
    logic [7:0] d;
    logic [63:0] rr;
    logic [7:0] shadow [52];

    always #10 core_clk = ~core_clk;

    atr_register_bank #(
        .PART_ID(ID_VAL)
    ) u_dut (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .host_req(host_req),
        .rd_data(rd_data),
        .rd_valid(rd_valid),
        .sample_valid(sample_valid),
        .raw_x(raw_x),
        .raw_y(raw_y),
        .raw_z(raw_z),
        .engine_status(engine_status),
        .config_out(config_out),
        .data_ready(data_ready)
    );

    atr_host_model u_host (
        .core_clk(core_clk),
        .rd_data(rd_data),
        .rd_valid(rd_valid),
        .host_req(host_req)
    );

    // writable bits per address; zero for read-only and unmapped
    function automatic logic [7:0] mask_of(input logic [7:0] a);
        case (a)
            8'h0e: return 8'h03;
            8'h0f: return 8'h33;
            8'h11: return 8'hc0;
            8'h13: return 8'hc7;
            8'h15: return 8'hf8;
            8'h1d: return 8'h1f;
            8'h23, 8'h24, 8'h25: return 8'h7f;
            8'h2b: return 8'hdf;
            8'h2c: return 8'h7b;
            8'h2d, 8'h2e: return 8'hbd;
            8'h12, 8'h14, 8'h17, 8'h18, 8'h1f, 8'h20, 8'h21: return 8'hff;
            default: return (a >= 8'h26 && a <= 8'h31) ? 8'hff : 8'h00;
        endcase
    endfunction : mask_of

    // read-only places whose contents come from the engines, the samples or the part identity
    function automatic bit is_ro(input logic [7:0] a);
        return a <= 8'h06 || (a >= 8'h0b && a <= 8'h0d) || a == 8'h10 ||
            a == 8'h16 || a == 8'h1e || a == 8'h22;
    endfunction : is_ro

    // corrected reading; full scale 3 shifts like 2, result saturates
    function automatic logic [9:0] corr(input logic [9:0] v,
            input logic [7:0] t, input logic [1:0] fs);
        int s;
        s = $signed(v) + ($signed(t) >>> ((fs == 2'd3) ? 3 : fs + 1));
        if (s > 511) s = 511;
        if (s < -512) s = -512;
        return s[9:0];
    endfunction : corr

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        u_host.rd(a, r);
        chk({7'd0, r}, {8'h01, e});
    endtask : rd_chk

    // one sample on all axes; #1 lets the taking edge settle
    task automatic sample(input logic [9:0] x, y, z);
        @(posedge core_clk);
        {sample_valid, raw_x, raw_y, raw_z} <= {1'b1, x, y, z};
        @(posedge core_clk);
        {sample_valid, raw_x, raw_y, raw_z} <= {1'b0, ~x, ~y, ~z};
        #1;
    endtask : sample

    // trims and full scale set, sample taken, corrected bytes read back
    task automatic trim_case(input logic [1:0] fs, input logic [2:0][7:0] t,
            input logic [2:0][9:0] v, input bit twice);
        logic [9:0] e;
        u_host.wr(ADDR_FULL_SCALE_CONFIG, {6'd0, fs});
        for (int i = 0; i < 3; i++) begin
            u_host.wr(ADDR_X_OFFSET_TRIM + 8'(i), t[i]);
        end
        sample(v[0], v[1], v[2]);
        if (twice) begin
            sample(v[0], v[1], v[2]);
        end
        chk({15'd0, data_ready}, 16'd1);
        chk({config_out.x_trim, config_out.z_trim}, {t[0], t[2]});
        chk({config_out.y_trim, 6'd0, config_out.full_scale},
            {t[1], 6'd0, fs});
        rd_chk(ADDR_DATA_STATUS, twice ? 8'hff : 8'h0f);
        for (int i = 0; i < 3; i++) begin
            e = corr(v[i], t[i], fs);
            rd_chk(ADDR_X_SAMPLE_HIGH + 8'(2 * i), e[9:2]);
            rd_chk(ADDR_X_SAMPLE_LOW + 8'(2 * i), {e[1:0], 6'd0});
        end
        // high-byte reads have cleared every ready flag
        chk({15'd0, data_ready}, 16'd0);
    endtask : trim_case

    task automatic tally_and_finish();
        if (n_errors == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : tally_and_finish

    // main sequence: reset, register sweeps, then offset correction
    initial begin
        void'($urandom(32'h4757_0c68));
        repeat (10) @(posedge core_clk);
        rst_n <= 1'b1;
        for (int a = 0; a < 52; a++) begin
            if (!is_ro(8'(a))) begin
                rd_chk(8'(a), 8'h00);
            end
        end
        rr = {$urandom, $urandom};
        @(posedge core_clk);
        engine_status <= rr[41:0];
        repeat (2) begin
            for (int a = 0; a < 52; a++) begin
                d = 8'($urandom);
                // keep the soft-reset bit clear so the sweep survives
                if (8'(a) == ADDR_SECONDARY_CONTROL) d &= 8'hbf;
                u_host.wr(8'(a), d);
                shadow[a] = d & mask_of(8'(a));
            end
            for (int a = 0; a < 52; a++) begin
                if (!is_ro(8'(a))) begin
                    rd_chk(8'(a), shadow[a]);
                end
            end
        end
        // settings copy follows the stored control and filter fields
        chk({11'd0, config_out.active, config_out.cutoff_select,
            config_out.tap_highpass_bypass, config_out.tap_lowpass_enable},
            {11'd0, shadow[42][0], shadow[15][1:0], shadow[15][5],
            shadow[15][4]});
        // write then read back with no idle cycle between them
        d = 8'($urandom);
        u_host.wr_rd(ADDR_Y_OFFSET_TRIM, d, r);
        chk({7'd0, r}, {8'h01, d});
        d = 8'($urandom);
        u_host.wr_rd(ADDR_TAP_FIRST_TIMER, d, r);
        chk({7'd0, r}, {8'h01, d});
        rd_chk(ADDR_PART_IDENTITY, ID_VAL);
        rd_chk(ADDR_OPERATING_STATE,
            {6'd0, engine_status.op_state});
        rd_chk(ADDR_TAP_SOURCE, engine_status.tap_src);
        u_host.wr(8'hff, 8'ha5);
        rd_chk(8'hff, 8'h00);
        // saturation at both ends and the smallest positive step on x
        trim_case(2'd0, {8'h7f, 8'h80, 8'h02},
            {10'h1ff, 10'h200, 10'h000}, 1'b0);
        trim_case(2'd3, {8'h80, 8'h01, 8'hff},
            {10'h155, 10'h2aa, 10'h000}, 1'b1);
        // most negative trim on a zero z reading at the 4g scale
        trim_case(2'd1, {8'h80, 8'h40, 8'hc0},
            {10'h000, 10'h3ff, 10'h100}, 1'b0);
        repeat (6) begin
            trim_case(2'($urandom), {8'($urandom), 8'($urandom), 8'($urandom)},
                {10'($urandom), 10'($urandom), 10'($urandom)},
                1'($urandom));
        end
        tally_and_finish();
    end

    // watchdog well beyond the several hundred cycles the tests need
    initial begin
        #(20 * 20000);
        n_errors++;
        tally_and_finish();
    end
endmodule : accel_register_map_offset_trim_bench

// ==== testbench/atr_host_model.sv ====
// host-side model that issues register reads and writes to the trim bank
`timescale 1ns/1ps
module atr_host_model
    import atr_pkg::*;
(
    input wire logic core_clk,
    input wire logic [7:0] rd_data,
    input wire logic rd_valid,
    output atr_host_req_type host_req
);
    // idle at time zero so the bank never sees an unknown strobe
    initial host_req = '0;

    // one write: strobe held over exactly one taken edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        host_req <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
        @(posedge core_clk);
        // released lines show the inverse so stale values never match
        host_req <= '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
    endtask : wr

    // write then read back on the very next edge, no idle cycle between
    task automatic wr_rd(input logic [7:0] a, input logic [7:0] d,
            output logic [8:0] r);
        @(posedge core_clk);
        host_req <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
        @(posedge core_clk);
        host_req <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: d};
        @(posedge core_clk);
        host_req <= '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
        #1;
        r = {rd_valid, rd_data};
    endtask : wr_rd

    // one read: answer and its valid flag taken in the answer cycle
    task automatic rd(input logic [7:0] a, output logic [8:0] r);
        @(posedge core_clk);
        host_req <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
        @(posedge core_clk);
        host_req <= '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: 8'hff};
        #1;
        r = {rd_valid, rd_data};
    endtask : rd
endmodule : atr_host_model
